// ===== asf_status_flags.sv
/*
 * ALU status flag register: derives N, OV, Z, DC and C from each add or
 * subtract, Z and N from logic ops and C and DC from rotates, and serves
 * the register as an ordinary file register.
 * Assumes the core's decode presents one operation per cycle with its
 * operands, and a file-register write port addressed by a select line.
 */
// Summary of operation
// RQ1 - Bits 7 to 5 are unimplemented and always read zero.
// RQ2 - Negative flag in bit 4 follows the result's most significant bit.
// RQ3 - Overflow flag bit 3 set when signed result changes sign wrongly.
// RQ4 - Zero flag bit 2 set when arithmetic or logic result is zero.
// RQ5 - Digit carry bit 1 takes carry out of bit 3 on add/subtract.
// RQ6 - Carry bit 0 takes carry out of the result MSB on add/subtract.
// RQ7 - Subtract adds two's complement; carries read as inverted borrows.
// RQ8 - Rotates load carry with the bit shifted out of the source.
// RQ9 - Rotates load digit carry with source bit 4 or bit 3.
// RQ10 - Flag-affecting write to this register updates flags, drops data.
// RQ11 - Bit set/clear, swap and moves leave all five flags untouched.
// RQ12 - Register is readable and writable like any file register.
// RQ13 - Updates visible next cycle; unaffected flags hold their value.
`timescale 1ns/1ps
`include "asf_consts.svh"

module asf_status_flags #(
  parameter int DATA_W = `ASF_DATA_W
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire asf_pkg::asf_op_t  op,
  input  wire logic [DATA_W-1:0] opnd_a,
  input  wire logic [DATA_W-1:0] opnd_b,
  input  wire logic [DATA_W-1:0] result,
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wr_data,
  output logic [DATA_W-1:0]      flags_rd,
  output logic [DATA_W-1:0]      alu_out
);

  // ***************************************************************
  // Arithmetic
  // ***************************************************************
  logic [DATA_W-1:0]     b_eff;
  logic [DATA_W:0]       sum;
  logic [`ASF_NIB_MSB+1:0] nib;
  logic                  is_arith;

  always_comb begin
    is_arith = (op == asf_pkg::ASF_OP_ADD) || (op == asf_pkg::ASF_OP_SUB);
    // Subtract as A + ~B + 1, so carries are inverted borrows (see RQ7)
    b_eff = (op == asf_pkg::ASF_OP_SUB) ? ~opnd_b : opnd_b;
    sum = {1'b0, opnd_a} + {1'b0, b_eff}
        + {{DATA_W{1'b0}}, op == asf_pkg::ASF_OP_SUB};
    nib = {1'b0, opnd_a[`ASF_NIB_MSB:0]} + {1'b0, b_eff[`ASF_NIB_MSB:0]}
        + {{(`ASF_NIB_MSB+1){1'b0}}, op == asf_pkg::ASF_OP_SUB};
    alu_out = is_arith ? sum[DATA_W-1:0] : result;
  end

  // ***************************************************************
  // Flag register
  // ***************************************************************
  logic [`ASF_FLAG_W-1:0] flags_q;
  logic [`ASF_FLAG_W-1:0] flags_d;
  logic [DATA_W-1:0]      res;

  always_comb begin
    flags_d = flags_q;   // Unaffected flags hold (see RQ13) (see RQ11)
    res = alu_out;
    // Plain write only when the op leaves flags alone (see RQ10) (see RQ12)
    if (wr_en && op == asf_pkg::ASF_OP_NONE) begin
      flags_d = wr_data[`ASF_FLAG_W-1:0];
    end
    unique case (op)
      asf_pkg::ASF_OP_NONE: begin
      end
      asf_pkg::ASF_OP_ADD, asf_pkg::ASF_OP_SUB: begin
        flags_d[`ASF_BIT_N]  = res[DATA_W-1];                 // see RQ2
        flags_d[`ASF_BIT_Z]  = (res == '0);                    // see RQ4
        flags_d[`ASF_BIT_OV] = (opnd_a[DATA_W-1] == b_eff[DATA_W-1])
                            && (res[DATA_W-1] != opnd_a[DATA_W-1]); // see RQ3
        flags_d[`ASF_BIT_DC] = nib[`ASF_NIB_MSB+1];            // see RQ5
        flags_d[`ASF_BIT_C]  = sum[DATA_W];                    // see RQ6
      end
      asf_pkg::ASF_OP_LOGIC: begin
        // Clearing this register sets Z and leaves N alone (see RQ10)
        if (!(wr_en && res == '0)) begin
          flags_d[`ASF_BIT_N] = res[DATA_W-1];                // see RQ2
        end
        flags_d[`ASF_BIT_Z] = (res == '0);                     // see RQ4
      end
      asf_pkg::ASF_OP_ROT_R: begin
        flags_d[`ASF_BIT_C]  = opnd_a[0];                      // see RQ8
        flags_d[`ASF_BIT_DC] = opnd_a[`ASF_SRC_DC_RR];         // see RQ9
      end
      asf_pkg::ASF_OP_ROT_L: begin
        flags_d[`ASF_BIT_C]  = opnd_a[DATA_W-1];               // see RQ8
        flags_d[`ASF_BIT_DC] = opnd_a[`ASF_SRC_DC_RL];         // see RQ9
      end
      default: begin
      end
    endcase
  end

  // Reset clears flags to a defined value; power-on value is unknown
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_rd = {`ASF_UNIMPL_VAL, flags_q};                // see RQ1

  // ***************************************************************
  // Assertions
  // ***************************************************************
  unimpl_zero_a: assert property (@(posedge sys_clk) // see RQ1
    flags_rd[DATA_W-1:`ASF_FLAG_W] == '0)
    else $error("Upper flag bits not zero");

  neg_flag_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ2
    is_arith |=> flags_q[`ASF_BIT_N] == $past(alu_out[DATA_W-1]))
    else $error("Negative flag wrong");

  ovf_flag_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ3
    (op == asf_pkg::ASF_OP_ADD && opnd_a == 8'h7F && opnd_b == 8'h01)
    |=> flags_q[`ASF_BIT_OV])
    else $error("Overflow not flagged");

  zero_flag_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ4
    (op == asf_pkg::ASF_OP_LOGIC) |=> flags_q[`ASF_BIT_Z] == ($past(result) == '0))
    else $error("Zero flag wrong");

  dc_flag_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ5
    (op == asf_pkg::ASF_OP_ADD && opnd_a == 8'h0F && opnd_b == 8'h01)
    |=> flags_q[`ASF_BIT_DC])
    else $error("Digit carry missed");

  borrow_pol_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ7
    (op == asf_pkg::ASF_OP_SUB)
    |=> flags_q[`ASF_BIT_C] == ($past(opnd_a) >= $past(opnd_b)))
    else $error("Borrow polarity wrong");

  rot_carry_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ8
    (op == asf_pkg::ASF_OP_ROT_L) |=> flags_q[`ASF_BIT_C] == $past(opnd_a[7]))
    else $error("Rotate carry wrong");

  dest_write_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ10
    (wr_en && op == asf_pkg::ASF_OP_LOGIC && result == '0)
    |=> flags_q == ($past(flags_q) | 5'h04))
    else $error("Flag destination write not dropped");

  hold_flags_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ11
    (op == asf_pkg::ASF_OP_NONE && !wr_en) |=> $stable(flags_q))
    else $error("Flags changed without cause");

  // Add carry out of the top bit, from the raw operands
  carry_add_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ6
    (op == asf_pkg::ASF_OP_ADD)
    |=> flags_q[`ASF_BIT_C]
        == (({1'b0, $past(opnd_a)} + {1'b0, $past(opnd_b)}) > 9'h0FF))
    else $error("Add carry wrong");

  // Digit borrow reads one when no borrow from the low nibble
  digit_borrow_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ7
    (op == asf_pkg::ASF_OP_SUB)
    |=> flags_q[`ASF_BIT_DC]
        == ($past(opnd_a[3:0]) >= $past(opnd_b[3:0])))
    else $error("Digit borrow polarity wrong");

  arith_zero_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ4
    is_arith |=> flags_q[`ASF_BIT_Z] == ($past(alu_out) == '0))
    else $error("Arithmetic zero flag wrong");

  // Rotate right takes carry from bit 0 and digit carry from bit 4
  rotr_carry_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ8
    (op == asf_pkg::ASF_OP_ROT_R) |=> flags_q[`ASF_BIT_C] == $past(opnd_a[0]))
    else $error("Rotate right carry wrong");

  rotr_dc_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ9
    (op == asf_pkg::ASF_OP_ROT_R) |=> flags_q[`ASF_BIT_DC] == $past(opnd_a[4]))
    else $error("Rotate right digit carry wrong");

  rotl_dc_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ9
    (op == asf_pkg::ASF_OP_ROT_L) |=> flags_q[`ASF_BIT_DC] == $past(opnd_a[3]))
    else $error("Rotate left digit carry wrong");

  // Rotates leave N, OV and Z as they were
  rot_keep_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ13
    (op == asf_pkg::ASF_OP_ROT_R || op == asf_pkg::ASF_OP_ROT_L)
    |=> flags_q[4:2] == $past(flags_q[4:2]))
    else $error("Rotate disturbed N, OV or Z");

  // Logic ops leave OV, DC and C as they were
  logic_keep_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ13
    (op == asf_pkg::ASF_OP_LOGIC)
    |=> flags_q[3] == $past(flags_q[3]) && flags_q[1:0] == $past(flags_q[1:0]))
    else $error("Logic op disturbed OV, DC or C");

  plain_write_a: assert property (@(posedge sys_clk) disable iff (rst) // see RQ12
    (wr_en && op == asf_pkg::ASF_OP_NONE)
    |=> flags_q == $past(wr_data[`ASF_FLAG_W-1:0]))
    else $error("Plain write not taken");

  reset_clear_a: assert property (@(posedge sys_clk) // see RQ13
    rst |=> flags_q == '0)
    else $error("Flags not cleared by reset");

  // ***************************************************************
  // Cover points
  // ***************************************************************
  cov_sub_c: cover property (@(posedge sys_clk) op == asf_pkg::ASF_OP_SUB);
  cov_rotl_c: cover property (@(posedge sys_clk) op == asf_pkg::ASF_OP_ROT_L);
  cov_wr_c: cover property (@(posedge sys_clk)
    wr_en && op == asf_pkg::ASF_OP_NONE);
  cov_rotr_c: cover property (@(posedge sys_clk) op == asf_pkg::ASF_OP_ROT_R);
  cov_clr_c: cover property (@(posedge sys_clk)
    wr_en && op == asf_pkg::ASF_OP_LOGIC && result == '0);

endmodule // asf_status_flags

// ===== asf_consts.svh
/*
 * Constants of the ALU status flag register: bit positions, widths and
 * the read value of the unimplemented upper bits.
 * Assumes inclusion by its bare name from the package or design file.
 */
`ifndef ASF_CONSTS_SVH
`define ASF_CONSTS_SVH

`define ASF_DATA_W       8
`define ASF_FLAG_W       5
`define ASF_BIT_C        0
`define ASF_BIT_DC       1
`define ASF_BIT_Z        2
`define ASF_BIT_OV       3
`define ASF_BIT_N        4
`define ASF_UNIMPL_VAL   3'h0
`define ASF_NIB_MSB      3
`define ASF_SRC_DC_RL    3
`define ASF_SRC_DC_RR    4

`endif

// ===== asf_pkg.sv
/*
 * Types of the ALU status flag register.
 * Assumes asf_consts.svh is on the include path.
 */
`include "asf_consts.svh"

package asf_pkg;

  // Flag-affecting operation class presented by the instruction decode
  typedef enum logic [3:0] {
    ASF_OP_NONE,     // Flags untouched (bit clear/set, swap, moves)
    ASF_OP_ADD,      // Register or literal add
    ASF_OP_SUB,      // Register or literal subtract
    ASF_OP_LOGIC,    // Logic op, clear: Z and N only
    ASF_OP_ROT_R,    // Rotate right through carry
    ASF_OP_ROT_L     // Rotate left through carry
  } asf_op_t;

endpackage

// ===== asf_alu_model.sv
/* ALU model of the core that feeds the flag block its result byte.
   Assumes the bench holds op and operands steady for a whole cycle. */
`timescale 1ns/1ps
module asf_alu_model (
  input  wire asf_pkg::asf_op_t op,
  input  wire logic [7:0]       opnd_a,
  input  wire logic [7:0]       opnd_b,
  output logic [7:0]            result
);
  // Plain circular rotate: only the source bits matter to the flags
  always_comb begin
    case (op)
      asf_pkg::ASF_OP_ADD:   result = opnd_a + opnd_b;
      asf_pkg::ASF_OP_SUB:   result = opnd_a - opnd_b;
      asf_pkg::ASF_OP_ROT_R: result = {opnd_a[0], opnd_a[7:1]};
      asf_pkg::ASF_OP_ROT_L: result = {opnd_a[6:0], opnd_a[7]};
      default:               result = opnd_a & opnd_b;
    endcase
  end
endmodule // asf_alu_model

// ===== asf_status_flags_bench.sv
/* Self-checking bench of the flag block beside the ALU model.
   Assumes asf_pkg is compiled first; assertions sit in the design. */
`timescale 1ns/1ps
module asf_status_flags_bench;
  typedef struct packed {
    logic [3:0] op;
    logic [7:0] a;
    logic [7:0] b;
    logic       wr;
    logic [7:0] wd;
    logic [7:0] ex;
  } asf_row_t;
  // Rows run back to back; the flags carry over from row to row
  asf_row_t rows [13] = '{
    '{4'h1, 8'h7F, 8'h01, 1'b0, 8'h00, 8'h1A},
    '{4'h1, 8'hFF, 8'h01, 1'b0, 8'h00, 8'h07},
    '{4'h2, 8'h05, 8'h03, 1'b0, 8'h00, 8'h03},
    '{4'h2, 8'h03, 8'h05, 1'b0, 8'h00, 8'h10},
    '{4'h2, 8'h80, 8'h01, 1'b0, 8'h00, 8'h09},
    '{4'h3, 8'hF0, 8'h0F, 1'b0, 8'h00, 8'h0D},
    '{4'h4, 8'h11, 8'h00, 1'b0, 8'h00, 8'h0F},
    '{4'h5, 8'h80, 8'h00, 1'b0, 8'h00, 8'h0D},
    '{4'h0, 8'h00, 8'h00, 1'b1, 8'hFF, 8'h1F},
    '{4'h0, 8'h00, 8'h00, 1'b1, 8'h0B, 8'h0B},
    '{4'h3, 8'h00, 8'h00, 1'b1, 8'hA5, 8'h0F},
    '{4'h0, 8'hAA, 8'h55, 1'b0, 8'h00, 8'h0F},
    '{4'h2, 8'h10, 8'h10, 1'b1, 8'h00, 8'h07}
  };
  logic             sys_clk = 1'b0;
  logic             rst     = 1'b1;
  logic             wr_en   = 1'b0;
  asf_pkg::asf_op_t op      = asf_pkg::ASF_OP_NONE;
  logic [7:0]       opnd_a  = 8'h00;
  logic [7:0]       opnd_b  = 8'h00;
  logic [7:0]       wr_data = 8'h00;
  logic [7:0]       result;
  logic [7:0]       flags_rd;
  logic [7:0]       alu_out;
  logic [7:0]       ex_alu;
  int               errors  = 0;
  int               checked = 0;

  asf_alu_model alu_u (.op(op), .opnd_a(opnd_a), .opnd_b(opnd_b),
                       .result(result));
  asf_status_flags dut_u (.sys_clk(sys_clk), .rst(rst), .op(op),
    .opnd_a(opnd_a), .opnd_b(opnd_b), .result(result), .wr_en(wr_en),
    .wr_data(wr_data), .flags_rd(flags_rd), .alu_out(alu_out));

  initial forever #2.5 sys_clk = ~sys_clk;

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    repeat (12) @(negedge sys_clk);
    chk("flags_rd", flags_rd, 8'h00);
    rst = 1'b0;
    foreach (rows[i]) begin
      @(negedge sys_clk);
      op = asf_pkg::asf_op_t'(rows[i].op);
      opnd_a = rows[i].a;
      opnd_b = rows[i].b;
      wr_en = rows[i].wr;
      wr_data = rows[i].wd;
      #1;
      ex_alu = (rows[i].op == 4'h1) ? rows[i].a + rows[i].b :
               (rows[i].op == 4'h2) ? rows[i].a - rows[i].b : result;
      chk("alu_out", alu_out, ex_alu);
      @(posedge sys_clk);
      #1 chk("flags_rd", flags_rd, rows[i].ex);
    end
    // Clear of the flag register sets Z only
    @(negedge sys_clk);
    op = asf_pkg::ASF_OP_NONE;
    wr_en = 1'b1;
    wr_data = 8'h1B;
    @(posedge sys_clk);
    #1 chk("flags_rd", flags_rd, 8'h1B);
    @(negedge sys_clk);
    op = asf_pkg::ASF_OP_LOGIC;
    opnd_a = 8'h00;
    opnd_b = 8'h00;
    wr_data = 8'hFF;
    @(posedge sys_clk);
    #1 chk("flags_rd", flags_rd, 8'h1F);
    // Reset again in mid-run
    @(negedge sys_clk);
    op = asf_pkg::ASF_OP_NONE;
    wr_en = 1'b0;
    rst = 1'b1;
    @(posedge sys_clk);
    #1 chk("flags_rd", flags_rd, 8'h00);
    @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    op = asf_pkg::ASF_OP_ADD;
    opnd_a = 8'h7F;
    opnd_b = 8'h01;
    @(posedge sys_clk);
    #1 chk("flags_rd", flags_rd, 8'h1A);
    conclude();
  end

  initial begin
    repeat (200) @(posedge sys_clk);
    errors++;
    conclude();
  end
endmodule // asf_status_flags_bench
